// ==== ocs_pkg.sv ====
// ocs_pkg: shared constants, codes and bus carriers for the clock source
// assumes: one 50 MHz system clock; AXI4-Lite register access
`default_nettype none
package ocs_pkg;

  ////////////////////////////////////////////////////////////
  // clock rates and internal oscillator model
  localparam longint CLK_HZ     = 50_000_000;
  localparam longint INT_4M_HZ  = 4_000_000;
  localparam longint INT_8M_HZ  = 8_000_000;
  localparam longint INT_12M_HZ = 12_800_000;
  localparam int     ACC_W      = 24;
  localparam longint ACC_SPAN   = 64'h0000_0000_0100_0000;
  // accumulator step for a toggle rate of twice the oscillator
  localparam logic [ACC_W-1:0] STEP_4M  =
    ACC_W'((2 * INT_4M_HZ * ACC_SPAN) / CLK_HZ);
  localparam logic [ACC_W-1:0] STEP_8M  =
    ACC_W'((2 * INT_8M_HZ * ACC_SPAN) / CLK_HZ);
  localparam logic [ACC_W-1:0] STEP_12M8 =
    ACC_W'((2 * INT_12M_HZ * ACC_SPAN) / CLK_HZ);
  localparam int     TRIM_W     = 8;
  localparam int     TRIM_SHIFT = 9;
  localparam logic [TRIM_W-1:0] TRIM_RST = 8'h00;

  ////////////////////////////////////////////////////////////
  // field codes
  localparam logic [1:0] SRC_INT    = 2'h0;
  localparam logic [1:0] SRC_DIRECT = 2'h1;
  localparam logic [1:0] SRC_RC     = 2'h2;
  localparam logic [1:0] SRC_XTAL   = 2'h3;
  localparam logic [1:0] FRQ_4M     = 2'h0;
  localparam logic [1:0] FRQ_8M     = 2'h1;
  localparam logic [1:0] FRQ_12M8   = 2'h2;
  localparam logic [1:0] FRQ_RSVD   = 2'h3;
  localparam logic [1:0] RNG_HIGH   = 2'h0;
  localparam logic [1:0] RNG_MID    = 2'h1;
  localparam logic [1:0] RNG_LOW    = 2'h2;
  localparam logic [1:0] RNG_RSVD   = 2'h3;
  localparam logic [1:0] EDGES_TO_ENGAGE = 2'h2;

  ////////////////////////////////////////////////////////////
  // register map and control word layout
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int STRB_W = DATA_W / BYTE_W;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] TRIM_ADDR = 8'h04;
  localparam int HIT_CTRL   = 0;
  localparam int HIT_TRIM   = 1;
  localparam int CB_SRC     = 0;
  localparam int CB_FREQ    = 2;
  localparam int CB_RANGE   = 4;
  localparam int CB_EXT_EN  = 6;
  localparam int CB_ENGAGED = 7;
  localparam int CB_PIN_OUT = 8;
  localparam int CB_RUN_STP = 9;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_INT = 3'b001,
    ST_ARM = 3'b010,
    ST_EXT = 3'b100
  } ocs_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } ocs_axil_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              arready;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic              rvalid;
  } ocs_axil_rsp_t;

endpackage : ocs_pkg
`default_nettype wire

// ==== ocs_int_osc.sv ====
// ocs_int_osc: trimmable internal oscillator as a phase accumulator
// assumes: system clock domain; tick_o marks each half period
`default_nettype none
module ocs_int_osc (
  input  wire logic                       clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       run_i,
  input  wire logic [1:0]                 freq_sel_i,
  input  wire logic [ocs_pkg::TRIM_W-1:0] trim_i,
  output logic                            tick_o
);
  import ocs_pkg::*;

  logic [ACC_W-1:0]        base_step;
  logic [ACC_W-1:0]        step;
  logic [ACC_W-1:0]        phase_reg;
  logic [ACC_W:0]          sum;
  logic signed [TRIM_W-1:0] trim_s;
  logic signed [ACC_W+1:0] base_s;
  logic signed [ACC_W+1:0] adj_s;
  logic signed [ACC_W+1:0] step_s;
  logic                    tick_reg;

  ////////////////////////////////////////////////////////////
  // nominal step; the reserved code is filtered upstream
  assign base_step = (freq_sel_i == FRQ_12M8) ? STEP_12M8 :  // RQ2
                     (freq_sel_i == FRQ_8M)   ? STEP_8M   :
                                                STEP_4M;
  // one trim count is 1/512 of nominal; larger trim, smaller step
  assign trim_s = trim_i;
  assign base_s = $signed({2'h0, base_step});
  assign adj_s  = $signed({{(TRIM_SHIFT+2){1'b0}},
                           base_step[ACC_W-1:TRIM_SHIFT]})
                  * (ACC_W+2)'(trim_s);
  assign step_s = base_s - adj_s;  // RQ6
  assign step   = step_s[ACC_W-1:0];
  assign sum    = {1'b0, phase_reg} + {1'b0, step};

  // carry out of the accumulator is a half-period tick
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !run_i) begin
      phase_reg <= '0;
      tick_reg  <= 1'b0;
    end else begin
      phase_reg <= sum[ACC_W-1:0];
      tick_reg  <= sum[ACC_W];
    end
  end

  assign tick_o = tick_reg;

  a_trim_slower: assert property (  // RQ6
    @(posedge clk_i) disable iff (!rstn_i)
    (trim_s > 0) |-> (step < base_step))
    else $error("positive trim did not lengthen period");

  a_trim_faster: assert property (  // RQ6
    @(posedge clk_i) disable iff (!rstn_i)
    (trim_s < 0) |-> (step > base_step))
    else $error("negative trim did not shorten period");

endmodule : ocs_int_osc
`default_nettype wire

// ==== ocs_clk_src.sv ====
// ocs_clk_src: oscillator source select and x4, x2, bus clock making
// assumes: 50 MHz clk_i, an AXI4-Lite master, oscillator pins outside
//
// What this block does
// [RQ1] bus clock is source clock over four
// [RQ2] internal osc 12.8/8/4 MHz, resets 4 MHz
// [RQ3] x4 clock equals source, feeds watchdog
// [RQ4] x2 clock is half of x4
// [RQ5] stop disables oscillators unless run option
// [RQ6] signed 8-bit trim, larger means slower
// [RQ7] software copies factory trim, never hardware
// [RQ8] software programs fields, waits, then enables
// [RQ9] software waits about 4096 crystal cycles
// [RQ10] external select enables input, crystal output
// [RQ11] two external rising edges before switching
// [RQ12] set engaged first, then stop internal
// [RQ13] clearing select and enable returns internal
// [RQ14] direct clock drives x4, pin output cleared
// [RQ15] crystal owns second pin, output bit ignored
// [RQ16] internal mode can drive x4 on pin
// [RQ17] software may precharge crystal via pin
// [RQ18] three crystal ranges, each own amplifier
// [RQ19] source codes internal, direct, RC, crystal
// [RQ20] frequency codes 4, 8, 12.8, reserved
// [RQ21] range codes high, mid, low, reserved
// [RQ22] engaged status bit shows external engagement
// [RQ23] reserved codes keep the current setting
`default_nettype none
module ocs_clk_src (
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire ocs_pkg::ocs_axil_req_t axil_req_i,
  output var  ocs_pkg::ocs_axil_rsp_t axil_rsp_o,
  input  wire logic                  stop_osc_enable_in_i,
  input  wire logic                  osc_in_pin_i,
  output logic                       osc_out_pin_o,
  output logic                       osc_out_pin_oe_o,
  output logic                       osc_in_pin_clk_en_o,
  output logic                       crystal_amp_en_o,
  output logic [1:0]                 crystal_range_o,
  output logic                       rc_osc_en_o,
  output logic                       internal_osc_run_o,
  output logic                       bus_clk_x4_b_o,
  output logic                       bus_clk_x2_c_o,
  output logic                       bus_clk_o,
  output logic                       watchdog_unit_clk_o
);
  import ocs_pkg::*;

  ////////////////////////////////////////////////////////////
  // state
  logic [1:0]        src_reg;
  logic [1:0]        freq_reg;
  logic [1:0]        range_reg;
  logic              ext_en_reg;
  logic              pin_out_reg;
  logic              run_stop_reg;
  logic [TRIM_W-1:0] trim_reg;
  logic              engaged_reg;
  logic              int_run_reg;
  ocs_state_t        state_reg;
  ocs_state_t        state_next;
  logic [1:0]        edge_cnt_reg;
  logic [1:0]        edge_cnt_next;
  logic              sync1_reg;
  logic              sync2_reg;
  logic              sync3_reg;
  logic              ext_lvl_reg;
  logic              ext_lvl_next;
  logic              ext_rise;
  logic              x4_reg;
  logic              x2_reg;
  logic              bus_reg;
  logic              x4_next;
  logic              x2_next;
  logic              bus_next;
  logic              osc_out_reg;
  logic              osc_out_oe_reg;
  logic              osc_out_next;
  logic              osc_out_oe_next;
  logic              osc_in_en_reg;
  logic              xtal_en_reg;
  logic              rc_en_reg;
  logic              osc_on;
  logic              int_tick;

  // bus side
  logic              aw_free_reg;
  logic              w_free_reg;
  logic              ar_free_reg;
  logic              bvalid_reg;
  logic              rvalid_reg;
  logic [1:0]        bresp_reg;
  logic [1:0]        rresp_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [STRB_W-1:0] w_strb_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] trim_word;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] ctrl_wr;
  logic [DATA_W-1:0] trim_wr;
  logic [1:0]        aw_hit;
  logic [1:0]        ar_hit;
  logic              aw_take;
  logic              w_take;
  logic              ar_take;
  logic              wr_go;
  logic              wr_ctrl;
  logic              wr_trim;
  logic [1:0]        src_next;
  logic [1:0]        freq_next;
  logic [1:0]        range_next;
  logic              pin_out_next;

  ////////////////////////////////////////////////////////////
  // word decode shared by the read and write paths
  function automatic logic [1:0] reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = '0;
    reg_hit[HIT_CTRL] = (a[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2]);
    reg_hit[HIT_TRIM] = (a[ADDR_W-1:2] == TRIM_ADDR[ADDR_W-1:2]);
  endfunction : reg_hit

  // byte-lane merge of a write into the stored word
  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [STRB_W-1:0] s);
    lane_merge = old_w;
    for (int i = 0; i < STRB_W; i++) begin
      if (s[i]) begin
        lane_merge[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
      end
    end
  endfunction : lane_merge

  ////////////////////////////////////////////////////////////
  // register read view; concatenation follows the CB_ positions
  assign ctrl_word = DATA_W'({run_stop_reg, pin_out_reg,
                              engaged_reg, ext_en_reg,  // RQ22
                              range_reg, freq_reg, src_reg});
  assign trim_word = DATA_W'(trim_reg);

  // handshakes: address and data are held until both are in
  assign aw_take = axil_req_i.awvalid && aw_free_reg;
  assign w_take  = axil_req_i.wvalid && w_free_reg;
  assign ar_take = axil_req_i.arvalid && ar_free_reg;
  assign wr_go   = !aw_free_reg && !w_free_reg && !bvalid_reg;
  assign aw_hit  = reg_hit(aw_addr_reg);
  assign ar_hit  = reg_hit(axil_req_i.araddr);
  assign wr_ctrl = wr_go && aw_hit[HIT_CTRL];
  assign wr_trim = wr_go && aw_hit[HIT_TRIM];
  assign ctrl_wr = lane_merge(ctrl_word, w_data_reg, w_strb_reg);
  assign trim_wr = lane_merge(trim_word, w_data_reg, w_strb_reg);
  assign rd_word = ar_hit[HIT_CTRL] ? ctrl_word :
                   ar_hit[HIT_TRIM] ? trim_word : '0;

  // field updates; reserved codes are dropped, not stored
  assign src_next   = wr_ctrl ? ctrl_wr[CB_SRC +: 2] : src_reg;  // RQ19
  assign freq_next  = (wr_ctrl && ctrl_wr[CB_FREQ +: 2] != FRQ_RSVD)
                    ? ctrl_wr[CB_FREQ +: 2] : freq_reg;  // RQ20 RQ23
  assign range_next = (wr_ctrl && ctrl_wr[CB_RANGE +: 2] != RNG_RSVD)
                    ? ctrl_wr[CB_RANGE +: 2] : range_reg;  // RQ21 RQ23
  // direct clock mode keeps the pin for its other functions
  assign pin_out_next = (src_next == SRC_DIRECT) ? 1'b0 :  // RQ14
                        wr_ctrl ? ctrl_wr[CB_PIN_OUT] : pin_out_reg;

  ////////////////////////////////////////////////////////////
  // AXI4-Lite slave flops
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      aw_free_reg <= 1'b1;
      w_free_reg  <= 1'b1;
      ar_free_reg <= 1'b1;
      bvalid_reg  <= 1'b0;
      rvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rresp_reg   <= RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      rdata_reg   <= '0;
    end else begin
      if (aw_take) begin
        aw_free_reg <= 1'b0;
        aw_addr_reg <= axil_req_i.awaddr;
      end else if (wr_go) begin
        aw_free_reg <= 1'b1;
      end
      if (w_take) begin
        w_free_reg <= 1'b0;
        w_data_reg <= axil_req_i.wdata;
        w_strb_reg <= axil_req_i.wstrb;
      end else if (wr_go) begin
        w_free_reg <= 1'b1;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (|aw_hit) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && axil_req_i.bready) begin
        bvalid_reg <= 1'b0;
      end
      if (ar_take) begin
        ar_free_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= rd_word;
        rresp_reg   <= (|ar_hit) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && axil_req_i.rready) begin
        ar_free_reg <= 1'b1;
        rvalid_reg  <= 1'b0;
      end
    end
  end

  assign axil_rsp_o = '{awready: aw_free_reg, wready: w_free_reg,
                        bresp: bresp_reg, bvalid: bvalid_reg,
                        arready: ar_free_reg, rdata: rdata_reg,
                        rresp: rresp_reg, rvalid: rvalid_reg};

  ////////////////////////////////////////////////////////////
  // software-visible fields; trim is never loaded by hardware
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      src_reg      <= SRC_INT;
      freq_reg     <= FRQ_4M;  // RQ2
      range_reg    <= RNG_HIGH;
      ext_en_reg   <= 1'b0;
      pin_out_reg  <= 1'b0;
      run_stop_reg <= 1'b0;
      trim_reg     <= TRIM_RST;
    end else begin
      src_reg     <= src_next;
      freq_reg    <= freq_next;
      range_reg   <= range_next;
      pin_out_reg <= pin_out_next;
      if (wr_ctrl) begin
        ext_en_reg   <= ctrl_wr[CB_EXT_EN];
        run_stop_reg <= ctrl_wr[CB_RUN_STP];
      end
      if (wr_trim) begin
        trim_reg <= trim_wr[TRIM_W-1:0];  // RQ6
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // oscillator pin: three stages, level accepted when two agree
  assign ext_lvl_next = (sync2_reg == sync3_reg) ? sync3_reg
                                                 : ext_lvl_reg;
  assign ext_rise     = ext_lvl_next && !ext_lvl_reg;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync1_reg   <= 1'b0;
      sync2_reg   <= 1'b0;
      sync3_reg   <= 1'b0;
      ext_lvl_reg <= 1'b0;
    end else begin
      sync1_reg   <= osc_in_pin_i;
      sync2_reg   <= sync1_reg;
      sync3_reg   <= sync2_reg;
      ext_lvl_reg <= ext_lvl_next;
    end
  end

  ////////////////////////////////////////////////////////////
  // stop gating: the run option overrides the stop disable
  assign osc_on = stop_osc_enable_in_i || run_stop_reg;  // RQ5

  ocs_int_osc u_int_osc (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .run_i      (int_run_reg),
    .freq_sel_i (freq_reg),
    .trim_i     (trim_reg),
    .tick_o     (int_tick)
  );

  ////////////////////////////////////////////////////////////
  // source switch; hand over only while both levels are high
  always_comb begin
    state_next    = state_reg;
    edge_cnt_next = '0;
    case (state_reg)
      ST_INT: begin
        if (ext_en_reg && src_reg != SRC_INT) begin
          state_next = ST_ARM;
        end
      end
      ST_ARM: begin
        edge_cnt_next = edge_cnt_reg;
        if (ext_rise && edge_cnt_reg != EDGES_TO_ENGAGE) begin
          edge_cnt_next = edge_cnt_reg + 2'h1;  // RQ11
        end
        if (!ext_en_reg) begin
          state_next = ST_INT;
        end else if (edge_cnt_reg == EDGES_TO_ENGAGE
                     && ext_lvl_reg && x4_reg) begin
          state_next = ST_EXT;  // RQ11 RQ12
        end
      end
      ST_EXT: begin
        if (src_reg == SRC_INT && !ext_en_reg) begin
          state_next = ST_INT;  // RQ13
        end
      end
      default: begin
        state_next = ST_INT;
      end
    endcase
  end

  // engaged is raised with the switch; internal stops a cycle later
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_reg    <= ST_INT;
      edge_cnt_reg <= '0;
      engaged_reg  <= 1'b0;
      int_run_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      edge_cnt_reg <= edge_cnt_next;
      engaged_reg  <= (state_next == ST_EXT);  // RQ12 RQ22
      int_run_reg  <= osc_on && !engaged_reg;  // RQ12 RQ5
    end
  end

  ////////////////////////////////////////////////////////////
  // clock chain: x4 from source, x2 and bus by halving
  assign x4_next  = (state_reg == ST_EXT) ? ext_lvl_reg :  // RQ3 RQ14
                    int_tick ? !x4_reg : x4_reg;
  assign x2_next  = (x4_next && !x4_reg) ? !x2_reg : x2_reg;  // RQ4
  assign bus_next = (x2_next && !x2_reg) ? !bus_reg : bus_reg;  // RQ1

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      x4_reg  <= 1'b0;
      x2_reg  <= 1'b0;
      bus_reg <= 1'b0;
    end else begin
      x4_reg  <= x4_next;
      x2_reg  <= x2_next;
      bus_reg <= bus_next;
    end
  end

  ////////////////////////////////////////////////////////////
  // pin sharing; crystal mode ignores the pin output bit
  always_comb begin
    osc_out_next    = 1'b0;
    osc_out_oe_next = 1'b0;
    case (src_reg)
      SRC_XTAL: begin
        osc_out_oe_next = 1'b1;  // RQ10 RQ15
        osc_out_next    = !ext_lvl_reg;
      end
      SRC_INT, SRC_RC: begin
        osc_out_oe_next = pin_out_reg;  // RQ16
        osc_out_next    = pin_out_reg && x4_next;
      end
      default: begin
        osc_out_oe_next = 1'b0;  // RQ14
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      osc_out_reg    <= 1'b0;
      osc_out_oe_reg <= 1'b0;
      osc_in_en_reg  <= 1'b0;
      xtal_en_reg    <= 1'b0;
      rc_en_reg      <= 1'b0;
    end else begin
      osc_out_reg    <= osc_out_next;
      osc_out_oe_reg <= osc_out_oe_next;
      osc_in_en_reg  <= (src_reg != SRC_INT);  // RQ10
      xtal_en_reg    <= (src_reg == SRC_XTAL) && osc_on;  // RQ18 RQ5
      rc_en_reg      <= (src_reg == SRC_RC) && osc_on;  // RQ5
    end
  end

  assign osc_out_pin_o       = osc_out_reg;
  assign osc_out_pin_oe_o    = osc_out_oe_reg;
  assign osc_in_pin_clk_en_o = osc_in_en_reg;
  assign crystal_amp_en_o    = xtal_en_reg;
  assign crystal_range_o     = range_reg;  // RQ18
  assign rc_osc_en_o         = rc_en_reg;
  assign internal_osc_run_o  = int_run_reg;
  assign bus_clk_x4_b_o      = x4_reg;
  assign bus_clk_x2_c_o      = x2_reg;
  assign bus_clk_o           = bus_reg;
  assign watchdog_unit_clk_o = x4_reg;  // RQ3

  ////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_arm_done;
    (state_reg == ST_ARM) ##1 (state_reg == ST_EXT);
  endsequence
  sequence s_engage;
    $rose(engaged_reg) ##0 int_run_reg;
  endsequence
  sequence s_go_home;
    (state_reg == ST_EXT) && (src_reg == SRC_INT) && !ext_en_reg;
  endsequence

  a_bus_quarter: assert property ( // RQ1
    $changed(bus_reg) |-> $rose(x2_reg))
    else $error("bus clock moved without an x2 rise");
  a_x2_half: assert property ( // RQ4
    $changed(x2_reg) |-> $rose(x4_reg))
    else $error("x2 clock moved without an x4 rise");
  a_reset_default: assert property ( // RQ2
    $rose(rstn_i) |-> src_reg == SRC_INT && freq_reg == FRQ_4M)
    else $error("reset left a non-default source");
  a_two_edges: assert property ( // RQ11
    s_arm_done |-> $past(edge_cnt_reg) == EDGES_TO_ENGAGE)
    else $error("switched before two external edges");
  a_engage_first: assert property ( // RQ12
    s_engage |=> !int_run_reg ##1 !int_run_reg)
    else $error("internal kept running after engage");
  a_stop_gate: assert property ( // RQ5
    !osc_on |=> !int_run_reg && !xtal_en_reg && !rc_en_reg)
    else $error("oscillator ran in stop");
  a_direct_pin: assert property ( // RQ14
    src_reg == SRC_DIRECT |-> !pin_out_reg ##1 !osc_out_oe_reg)
    else $error("pin output left set in direct mode");
  a_xtal_pin: assert property ( // RQ15
    src_reg == SRC_XTAL |=> osc_out_oe_reg && osc_in_en_reg)
    else $error("crystal mode did not own both pins");
  a_int_pin_out: assert property ( // RQ16
    src_reg == SRC_INT && pin_out_reg |=> osc_out_oe_reg
      && osc_out_reg == x4_reg)
    else $error("x4 not driven on pin");
  a_return_int: assert property ( // RQ13
    s_go_home |=> state_reg == ST_INT && !engaged_reg)
    else $error("did not return to internal source");
  a_rsvd_freq: assert property ( // RQ23
    wr_ctrl && ctrl_wr[CB_FREQ +: 2] == FRQ_RSVD |=> $stable(freq_reg))
    else $error("reserved frequency code was taken");
  a_ext_follow: assert property ( // RQ14
    state_reg == ST_EXT |=> x4_reg == $past(ext_lvl_reg))
    else $error("x4 does not follow the external clock");

endmodule : ocs_clk_src
`default_nettype wire

// ==== ocs_ext_src.sv ====
// ocs_ext_src: external clock source model on the first oscillator pin
// assumes: stepped by the bench clock; pin rests low while stopped
`default_nettype none
module ocs_ext_src #(
  parameter int HALF = 4
) (
  input  wire logic clk_i,
  input  wire logic run_i,
  output var  logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q = 0;
  initial pin_o = 1'b0;
  // toggles every HALF cycles; driven low while stopped, so no rising edges
  always @(posedge clk_i) begin
    if (!run_i) begin
      pin_o <= 1'b0;
      cnt_q <= 0;
    end else if (cnt_q == HALF - 1) begin
      pin_o <= ~pin_o;
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule : ocs_ext_src
`default_nettype wire

// ==== test_ocs_clk_src.sv ====
// test_ocs_clk_src: self-checking bench for the clock source block
// assumes: ocs_pkg, ocs_clk_src and ocs_ext_src compiled first
`default_nettype none
module test_ocs_clk_src;
  timeunit 1ns;
  timeprecision 1ps;
  import ocs_pkg::*;
  logic clk_i = 1'b0, rstn_i = 1'b0, stop_i = 1'b1, run_q = 1'b0;
  logic pin, oe, ien, amp, rce, irun, x4, x2, bc, po, wd;
  logic [1:0] rng, r;
  logic [31:0] d;
  ocs_axil_req_t rq = '0;
  ocs_axil_rsp_t rs;
  int failures = 0, checks = 0, cyc = 0, n, m, k;
  ocs_ext_src #(.HALF(4)) u_src (.clk_i(clk_i), .run_i(run_q), .pin_o(pin));
  ocs_clk_src DUT (.clk_i(clk_i), .rstn_i(rstn_i), .axil_req_i(rq),
    .axil_rsp_o(rs), .stop_osc_enable_in_i(stop_i), .osc_in_pin_i(pin),
    .osc_out_pin_o(po), .osc_out_pin_oe_o(oe), .osc_in_pin_clk_en_o(ien),
    .crystal_amp_en_o(amp), .crystal_range_o(rng), .rc_osc_en_o(rce),
    .internal_osc_run_o(irun), .bus_clk_x4_b_o(x4), .bus_clk_x2_c_o(x2),
    .bus_clk_o(bc), .watchdog_unit_clk_o(wd));
  ////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic pause(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask : pause
  // ready levels are flop outputs, so pre-edge values are read here
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    rq.awaddr <= a;
    rq.wdata <= v;
    rq.wstrb <= 4'hf;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      if (rs.awready && rq.awvalid) rq.awvalid <= 1'b0;
      if (rs.wready && rq.wvalid) rq.wvalid <= 1'b0;
    end while (rs.bvalid !== 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      if (rs.arready) rq.arvalid <= 1'b0;
    end while (rs.rvalid !== 1'b1);
    d = rs.rdata;
    r = rs.rresp;
  endtask : rd
  // rising edges of x4, x2 and bus clock over 1000 cycles
  task automatic count();
    logic p4, p2, pb;
    n = 0; m = 0; k = 0; p4 = x4; p2 = x2; pb = bc;
    repeat (1000) begin
      @(posedge clk_i);
      n += int'(x4 === 1'b1 && p4 === 1'b0);
      m += int'(x2 === 1'b1 && p2 === 1'b0);
      k += int'(bc === 1'b1 && pb === 1'b0);
      p4 = x4; p2 = x2; pb = bc;
    end
  endtask : count
  task automatic rate(input int e);
    count();
    chk(32'(n >= e - 1 && n <= e + 1), 32'h1);
    chk(32'(m >= e / 2 - 1 && m <= e / 2 + 1), 32'h1);
    chk(32'(k >= e / 4 - 1 && k <= e / 4 + 1), 32'h1);
  endtask : rate
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(CTRL_ADDR); chk(d, 32'h0);
    rd(TRIM_ADDR); chk(d, 32'h0);
    rd(8'h08); chk(32'(r), 32'(RESP_SLVERR));
    rate(80);
  endtask : t_reset
  task automatic t_freq();
    wr(CTRL_ADDR, 32'h004); rate(160);
    wr(CTRL_ADDR, 32'h008); rate(256);
    wr(CTRL_ADDR, 32'h00c); rd(CTRL_ADDR); chk(d, 32'h008);
    wr(CTRL_ADDR, 32'h0);
    wr(TRIM_ADDR, 32'h7f); count(); chk(32'(n < 75), 32'h1);
    wr(TRIM_ADDR, 32'h80); count(); chk(32'(n > 85), 32'h1);
    wr(TRIM_ADDR, 32'h0);
  endtask : t_freq
  // fields first, no pin edges yet: enable alone must not switch
  task automatic t_switch();
    wr(CTRL_ADDR, 32'h101); pause(3);
    chk(32'(ien), 32'h1);
    chk(32'(oe), 32'h0);
    wr(CTRL_ADDR, 32'h141); pause(40);
    rd(CTRL_ADDR); chk(d, 32'h041);
    run_q <= 1'b1;
    n = 0;
    while (irun !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    rd(CTRL_ADDR); chk(d, 32'h0c1);
    chk(32'(irun), 32'h0);
    rate(125);
    wr(CTRL_ADDR, 32'h0); pause(4);
    rd(CTRL_ADDR); chk(d, 32'h0);
    chk(32'(irun), 32'h1);
    run_q <= 1'b0;
    rate(80);
  endtask : t_switch
  task automatic t_pins();
    for (int i = 0; i < 3; i++) begin
      wr(CTRL_ADDR, 32'h103 | 32'(i << 4)); pause(3);
      chk(32'(amp), 32'h1);
      chk(32'(rng), 32'(i));
      chk(32'(oe), 32'h1);
      chk(32'(po), 32'h1);
    end
    wr(CTRL_ADDR, 32'h133); rd(CTRL_ADDR); chk(d, 32'h123);
    // crystal: let it run its start-up count, then engage it
    run_q <= 1'b1;
    repeat (4096) @(posedge pin);
    wr(CTRL_ADDR, 32'h163); pause(60);
    rd(CTRL_ADDR); chk(d, 32'h1e3);
    wr(CTRL_ADDR, 32'h0); run_q <= 1'b0; pause(4);
    wr(CTRL_ADDR, 32'h002); pause(3);
    chk(32'(rce), 32'h1);
    chk(32'(amp), 32'h0);
    wr(CTRL_ADDR, 32'h100); pause(3);
    chk(32'(oe), 32'h1);
    chk(32'(po), 32'(x4));
    chk(32'(wd), 32'(x4));
    stop_i <= 1'b0; pause(3);
    chk(32'(irun), 32'h0);
    wr(CTRL_ADDR, 32'h200); pause(3);
    chk(32'(irun), 32'h1);
    stop_i <= 1'b1;
  endtask : t_pins
  ////////////////////////////////////////////////////////////
  initial forever #10 clk_i = ~clk_i;
  // hang guard, well above the planned run length
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    rq.bready <= 1'b1;
    rq.rready <= 1'b1;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_freq();
    t_switch();
    t_pins();
    end_of_test();
  end
endmodule : test_ocs_clk_src
`default_nettype wire
